// *** src/rsoc_regs.svh ***
// How it works
// - Configuration word sits at 2007h; erased value is 3FFFh.
// - Clock source is one of four modes picked by two bits.
// - Mode code 11 RC, 10 high-speed, 01 crystal, 00 low-power.
// - Crystal modes drive the oscillator across both oscillator pins.
// - High-speed mode also accepts an external clock on the input pin.
// - Six reset kinds: power-on, clear running/asleep, watchdog, wake-up, brown-out.
// - Some registers are never reset; undefined at power-on, kept otherwise.
// - The user register loads its reset value on every reset kind but wake-up; the other registers but the keep register only on the block reset.
// - Watchdog wake-up loads no reset values; execution resumes.
// - Timeout and powerdown flags take a pattern per reset kind.
// - Power-on sets both; watchdog clears timeout; watchdog wake clears both; sleep-clear clears powerdown.
// - All kinds but wake-ups load address zero; wake-ups continue.
// - Master-clear path filters out short pulses.
// - Watchdog reset never drives the master-clear pin low.
// - Internal power-on pulse when supply rise is detected.
`ifndef RSOC_REGS_SVH
`define RSOC_REGS_SVH
`define RSOC_ADDR_W 14
`define RSOC_DATA_W 14
`define RSOC_CFG_ADDR 14'h2007
`define RSOC_CFG_RST 14'h3fff
`define RSOC_CFG_IMPL 14'h005f
`define RSOC_FLAG_ADDR 14'h2000
`define RSOC_IST_ADDR 14'h2001
`define RSOC_IMSK_ADDR 14'h2002
`define RSOC_USER_ADDR 14'h2003
`define RSOC_KEEP_ADDR 14'h2004
`define RSOC_USER_RST 8'h00
`define RSOC_IMSK_RST 6'h00
`define RSOC_CFG_MODE_LSB 0
`define RSOC_CFG_WDTEN_BIT 2
`define RSOC_CFG_BOREN_BIT 6
`define RSOC_CLK_NS 25
`define RSOC_MASTER_CLEAR_N_MIN_NS 100
`define RSOC_MASTER_CLEAR_N_FILT_CYC ((`RSOC_MASTER_CLEAR_N_MIN_NS + `RSOC_CLK_NS - 1) / `RSOC_CLK_NS)
`endif

// *** src/rsoc_pkg.sv ***
package rsoc_pkg;
    typedef enum logic [1:0] {
        RSOC_LOW_POWER_CRYSTAL_MODE = 2'h0,
        RSOC_CRYSTAL_RESONATOR_MODE = 2'h1,
        RSOC_HIGH_SPEED_CRYSTAL_MODE = 2'h2,
        RSOC_RESISTOR_CAPACITOR_MODE = 2'h3
    } rsoc_osc_mode_type;
    typedef enum logic [2:0] {
        RSOC_K_POR,
        RSOC_K_CLR_RUN,
        RSOC_K_CLR_SLEEP,
        RSOC_K_WDOG_RUN,
        RSOC_K_WDOG_WAKE,
        RSOC_K_BROWNOUT,
        RSOC_K_NONE
    } rsoc_kind_type;
    typedef enum {RSOC_IDLE, RSOC_HOLD} rsoc_state_type;
endpackage : rsoc_pkg

// *** src/rsoc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module rsoc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Level in and out
    input wire logic async_i,
    output logic sync_o
);
    logic meta_r;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule : rsoc_sync
`default_nettype wire

// *** src/rsoc_master_clear_n_filter.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rsoc_regs.svh"
module rsoc_master_clear_n_filter #(
    parameter int unsigned FILT_CYC = `RSOC_MASTER_CLEAR_N_FILT_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Pin and qualified level
    input wire logic master_clear_n_i,
    output logic asserted_o
);
    localparam int unsigned CW = $clog2(FILT_CYC + 1);
    logic pin_s;
    logic [CW-1:0] cnt_r;

    rsoc_sync #(.RST_VAL(1'b1)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(master_clear_n_i),
        .sync_o(pin_s)
    );

    // Release is immediate; only assertion is qualified
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            asserted_o <= 1'b0;
        end else if (pin_s) begin
            cnt_r <= '0;
            asserted_o <= 1'b0;
        end else if (cnt_r == CW'(FILT_CYC)) begin
            asserted_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    a_filter_qualify: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(asserted_o) |-> $past(cnt_r) == CW'(FILT_CYC) && !$past(pin_s))
        else $error("Master clear taken before qualification");
endmodule : rsoc_master_clear_n_filter
`default_nettype wire

// *** src/rsoc_top.sv ***
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "rsoc_regs.svh"
module rsoc_top #(
    parameter int unsigned FILT_CYC = `RSOC_MASTER_CLEAR_N_FILT_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [`RSOC_ADDR_W-1:0] addr_i,
    input wire logic [`RSOC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`RSOC_DATA_W-1:0] rdata_o,
    // Reset sources
    input wire logic master_clear_n_i,
    input wire logic supply_rise_i,
    input wire logic brownout_reset_i,
    input wire logic watchdog_i,
    input wire logic sleep_i,
    input wire logic int_wake_i,
    // Master-clear pin drive
    output logic master_clear_n_o,
    output logic master_clear_oe_n_o,
    // Oscillator control
    output rsoc_pkg::rsoc_osc_mode_type osc_mode_o,
    output logic osc_both_pins_o,
    output logic ext_clk_accept_o,
    // Core reset results
    output logic core_rst_o,
    output logic pc_zero_o,
    output logic resume_o,
    output logic [5:0] cause_o,
    output logic timeout_flag_o,
    output logic powerdown_flag_o,
    // Interrupt
    output logic irq_o
);
    import rsoc_pkg::*;

    logic master_clear_n_act;
    logic bor_s;
    logic rise_s;
    logic rise_d_r;
    logic por_pend_r;
    logic [`RSOC_DATA_W-1:0] cfg_r;
    logic [7:0] user_r;
    logic [7:0] keep_r;
    logic [5:0] ist_r;
    logic [5:0] imsk_r;
    logic [5:0] fin_bits;
    rsoc_state_type st_r;
    rsoc_kind_type kind_r;
    rsoc_kind_type kind_nxt;
    logic hold;
    logic fin;
    logic int_wake;
    logic wr_cfg;
    logic wr_ist;
    logic wr_imsk;
    logic wr_user;
    logic wr_keep;

    rsoc_master_clear_n_filter #(.FILT_CYC(FILT_CYC)) u_filt (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .master_clear_n_i(master_clear_n_i),
        .asserted_o(master_clear_n_act)
    );

    rsoc_sync #(.RST_VAL(1'b0)) u_bor_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(brownout_reset_i),
        .sync_o(bor_s)
    );

    rsoc_sync #(.RST_VAL(1'b0)) u_rise_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(supply_rise_i),
        .sync_o(rise_s)
    );

    assign wr_cfg = wr_i && addr_i == `RSOC_CFG_ADDR;
    assign wr_ist = wr_i && addr_i == `RSOC_IST_ADDR;
    assign wr_imsk = wr_i && addr_i == `RSOC_IMSK_ADDR;
    assign wr_user = wr_i && addr_i == `RSOC_USER_ADDR;
    assign wr_keep = wr_i && addr_i == `RSOC_KEEP_ADDR;

    // Supply rise edge, and the block reset itself, both mean power-on
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rise_d_r <= 1'b0;
            por_pend_r <= 1'b1;
        end else begin
            rise_d_r <= rise_s;
            if (rise_s && !rise_d_r) begin
                por_pend_r <= 1'b1;
            end else if (st_r == RSOC_IDLE) begin
                por_pend_r <= 1'b0;
            end
        end
    end

    // Unimplemented bits read as one; only implemented bits are programmable
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_r <= `RSOC_CFG_RST;
        end else if (wr_cfg) begin
            cfg_r <= (wdata_i & `RSOC_CFG_IMPL) | ~`RSOC_CFG_IMPL;
        end
    end

    // Priority: power-on, brown-out, master clear, watchdog
    always_comb begin
        kind_nxt = RSOC_K_NONE;
        if (por_pend_r) begin
            kind_nxt = RSOC_K_POR;
        end else if (bor_s && cfg_r[`RSOC_CFG_BOREN_BIT]) begin
            kind_nxt = RSOC_K_BROWNOUT;
        end else if (master_clear_n_act) begin
            kind_nxt = sleep_i ? RSOC_K_CLR_SLEEP : RSOC_K_CLR_RUN;
        end else if (watchdog_i && cfg_r[`RSOC_CFG_WDTEN_BIT]) begin
            kind_nxt = sleep_i ? RSOC_K_WDOG_WAKE : RSOC_K_WDOG_RUN;
        end
    end

    // Level sources hold the reset; pulse sources last one cycle
    always_comb begin
        case (kind_r)
            RSOC_K_BROWNOUT: hold = bor_s && cfg_r[`RSOC_CFG_BOREN_BIT];
            RSOC_K_CLR_RUN,
            RSOC_K_CLR_SLEEP: hold = master_clear_n_act;
            default: hold = 1'b0;
        endcase
    end

    assign fin = st_r == RSOC_HOLD && !hold;
    assign int_wake = st_r == RSOC_IDLE && kind_nxt == RSOC_K_NONE && sleep_i && int_wake_i;

    always_comb begin
        fin_bits = 6'h00;
        if (fin) begin
            case (kind_r)
                RSOC_K_POR: fin_bits = 6'h01;
                RSOC_K_CLR_RUN: fin_bits = 6'h02;
                RSOC_K_CLR_SLEEP: fin_bits = 6'h04;
                RSOC_K_WDOG_RUN: fin_bits = 6'h08;
                RSOC_K_WDOG_WAKE: fin_bits = 6'h10;
                RSOC_K_BROWNOUT: fin_bits = 6'h20;
                default: fin_bits = 6'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_r <= RSOC_IDLE;
            kind_r <= RSOC_K_NONE;
        end else begin
            case (st_r)
                RSOC_IDLE: begin
                    if (kind_nxt != RSOC_K_NONE) begin
                        st_r <= RSOC_HOLD;
                        kind_r <= kind_nxt;
                    end
                end
                RSOC_HOLD: begin
                    if (!hold) begin
                        st_r <= RSOC_IDLE;
                    end
                end
                default: st_r <= RSOC_IDLE;
            endcase
        end
    end

    // Wake-up keeps the core running; every other kind resets it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            core_rst_o <= 1'b1;
        end else if (st_r == RSOC_IDLE) begin
            core_rst_o <= kind_nxt != RSOC_K_NONE && kind_nxt != RSOC_K_WDOG_WAKE;
        end else if (fin) begin
            core_rst_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pc_zero_o <= 1'b0;
            resume_o <= 1'b0;
        end else begin
            pc_zero_o <= fin && kind_r != RSOC_K_WDOG_WAKE;
            resume_o <= (fin && kind_r == RSOC_K_WDOG_WAKE) || int_wake;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cause_o <= 6'h00;
        end else if (fin) begin
            cause_o <= fin_bits;
        end
    end

    // Master clear while running leaves both flags as they were
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            timeout_flag_o <= 1'b1;
            powerdown_flag_o <= 1'b1;
        end else if (int_wake) begin
            timeout_flag_o <= 1'b1;
            powerdown_flag_o <= 1'b0;
        end else if (fin) begin
            case (kind_r)
                RSOC_K_POR,
                RSOC_K_BROWNOUT: begin
                    timeout_flag_o <= 1'b1;
                    powerdown_flag_o <= 1'b1;
                end
                RSOC_K_CLR_SLEEP: begin
                    timeout_flag_o <= 1'b1;
                    powerdown_flag_o <= 1'b0;
                end
                RSOC_K_WDOG_RUN: begin
                    timeout_flag_o <= 1'b0;
                    powerdown_flag_o <= 1'b1;
                end
                RSOC_K_WDOG_WAKE: begin
                    timeout_flag_o <= 1'b0;
                    powerdown_flag_o <= 1'b0;
                end
                default: begin
                    timeout_flag_o <= timeout_flag_o;
                    powerdown_flag_o <= powerdown_flag_o;
                end
            endcase
        end
    end

    // Reset-state register: cleared by core reset, kept over wake-up
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || core_rst_o) begin
            user_r <= `RSOC_USER_RST;
        end else if (wr_user) begin
            user_r <= wdata_i[7:0];
        end
    end

    // No reset at all, by design: contents survive every reset kind
    always_ff @(posedge ref_clk_i) begin
        if (wr_keep) begin
            keep_r <= wdata_i[7:0];
        end
    end

    // Set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ist_r <= 6'h00;
            imsk_r <= `RSOC_IMSK_RST;
            irq_o <= 1'b0;
        end else begin
            ist_r <= (ist_r & ~(wr_ist ? wdata_i[5:0] : 6'h00)) | fin_bits;
            if (wr_imsk) begin
                imsk_r <= wdata_i[5:0];
            end
            irq_o <= |(ist_r & imsk_r);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                `RSOC_CFG_ADDR: rdata_o <= cfg_r;
                `RSOC_FLAG_ADDR: rdata_o <= {6'h00, cause_o, powerdown_flag_o, timeout_flag_o};
                `RSOC_IST_ADDR: rdata_o <= {8'h00, ist_r};
                `RSOC_IMSK_ADDR: rdata_o <= {8'h00, imsk_r};
                `RSOC_USER_ADDR: rdata_o <= {6'h00, user_r};
                `RSOC_KEEP_ADDR: rdata_o <= {6'h00, keep_r};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    // Mode decode follows the two select bits directly
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            osc_mode_o <= RSOC_RESISTOR_CAPACITOR_MODE;
            osc_both_pins_o <= 1'b0;
            ext_clk_accept_o <= 1'b0;
        end else begin
            osc_mode_o <= rsoc_osc_mode_type'(cfg_r[`RSOC_CFG_MODE_LSB +: 2]);
            osc_both_pins_o <= cfg_r[`RSOC_CFG_MODE_LSB +: 2] != 2'h3;
            ext_clk_accept_o <= cfg_r[`RSOC_CFG_MODE_LSB +: 2] == 2'h2;
        end
    end

    // Watchdog reset stays internal, so the pin is never driven
    always_ff @(posedge ref_clk_i) begin
        master_clear_n_o <= 1'b1;
        master_clear_oe_n_o <= 1'b1;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_finish(rsoc_kind_type k);
        fin && kind_r == k;
    endsequence

    a_por_flags: assert property (s_finish(RSOC_K_POR) |=> timeout_flag_o && powerdown_flag_o)
        else $error("Power-on flags wrong");
    a_wdog_flags: assert property (s_finish(RSOC_K_WDOG_RUN) |=> !timeout_flag_o && powerdown_flag_o)
        else $error("Watchdog reset flags wrong");
    a_sleep_clear_flags: assert property (s_finish(RSOC_K_CLR_SLEEP) |=> timeout_flag_o && !powerdown_flag_o)
        else $error("Sleep master clear flags wrong");
    a_wake_resume: assert property (s_finish(RSOC_K_WDOG_WAKE)
        |=> resume_o && !pc_zero_o && !core_rst_o && !timeout_flag_o && !powerdown_flag_o)
        else $error("Watchdog wake did not resume");
    a_reset_pc_zero: assert property (fin && kind_r != RSOC_K_WDOG_WAKE |=> pc_zero_o ##1 !pc_zero_o)
        else $error("Address zero pulse missing");
    a_cause_onehot: assert property (fin |=> $onehot(cause_o) && $onehot(ist_r & $past(fin_bits)))
        else $error("Cause vector not one-hot");
    a_pin_undriven: assert property (master_clear_oe_n_o && master_clear_n_o)
        else $error("Master clear pin driven");
    a_ext_clock_hs: assert property (##1 ext_clk_accept_o == ($past(cfg_r[1:0]) == 2'h2))
        else $error("External clock accept mismatch");
    a_clr_hold: assert property (st_r == RSOC_HOLD && master_clear_n_act && kind_r == RSOC_K_CLR_RUN
        |=> core_rst_o)
        else $error("Core reset dropped during master clear");
endmodule : rsoc_top
`default_nettype wire

// *** test/rsoc_board_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rsoc_board_model (
    // Clock
    input wire logic ref_clk_i,
    // Bench commands
    input wire logic clr_go_i,
    input wire logic [7:0] clr_cycles_i,
    input wire logic pwr_go_i,
    // Device side of the pin
    input wire logic pin_drv_i,
    input wire logic pin_oe_n_i,
    // Board signals
    output logic master_clear_n_o,
    output logic supply_rise_o
);
    logic [7:0] hold_cnt_r = 8'h00;
    logic supply_r = 1'b0;
    // Pull-up on the pin: low only while the board or the device pulls it
    assign master_clear_n_o = (hold_cnt_r == 8'h00) & (pin_oe_n_i | pin_drv_i);
    assign supply_rise_o = supply_r;
    always_ff @(posedge ref_clk_i) begin
        if (clr_go_i) begin
            hold_cnt_r <= clr_cycles_i;
        end else if (hold_cnt_r != 8'h00) begin
            hold_cnt_r <= hold_cnt_r - 8'h01;
        end
    end
    // Supply stays low until asked, so exactly one rise is seen
    always_ff @(posedge ref_clk_i) begin
        if (pwr_go_i) begin
            supply_r <= 1'b1;
        end
    end
endmodule : rsoc_board_model
`default_nettype wire

// *** test/tb_rsoc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rsoc_regs.svh"
module tb_rsoc_top;
    import rsoc_pkg::*;
    // Short filter keeps the boundary pulses brief
    localparam int unsigned FILT = 2;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [13:0] addr_i = 14'h0000;
    logic [13:0] wdata_i = 14'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [13:0] rdata_o;
    logic master_clear_n_in, supply, master_clear_n_drv, master_clear_n_oe_n, both, ext, core_rst_o, pc_zero_o, resume_o, tof, pdf, irq_o;
    logic bo = 1'b0;
    logic wd = 1'b0;
    logic sleep = 1'b0;
    logic iwake = 1'b0;
    logic clr_go = 1'b0;
    logic pwr_go = 1'b0;
    logic [7:0] clr_cycles = 8'h00;
    rsoc_osc_mode_type osc_mode;
    logic [5:0] cause;
    int mismatches = 0;
    int n_tests = 0;
    int cyc = 0;
    rsoc_top #(.FILT_CYC(FILT)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .master_clear_n_i(master_clear_n_in), .supply_rise_i(supply),
        .brownout_reset_i(bo), .watchdog_i(wd), .sleep_i(sleep), .int_wake_i(iwake),
        .master_clear_n_o(master_clear_n_drv), .master_clear_oe_n_o(master_clear_n_oe_n), .osc_mode_o(osc_mode),
        .osc_both_pins_o(both), .ext_clk_accept_o(ext), .core_rst_o(core_rst_o), .pc_zero_o(pc_zero_o),
        .resume_o(resume_o), .cause_o(cause), .timeout_flag_o(tof), .powerdown_flag_o(pdf), .irq_o(irq_o));
    rsoc_board_model board_u (.ref_clk_i(ref_clk_i), .clr_go_i(clr_go), .clr_cycles_i(clr_cycles),
        .pwr_go_i(pwr_go), .pin_drv_i(master_clear_n_drv), .pin_oe_n_i(master_clear_n_oe_n), .master_clear_n_o(master_clear_n_in),
        .supply_rise_o(supply));
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    task automatic close_out;
        $display("Checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    // Generous ceiling: the whole run needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [13:0] a, input logic [13:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd_chk(input string n, input logic [13:0] a, input logic [13:0] e);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(n, e, rdata_o);
    endtask : rd_chk
    task automatic pulse_wd;
        @(posedge ref_clk_i);
        wd <= 1'b1;
        @(posedge ref_clk_i);
        wd <= 1'b0;
    endtask : pulse_wd
    task automatic pin_low(input logic [7:0] n);
        @(posedge ref_clk_i);
        clr_cycles <= n;
        clr_go <= 1'b1;
        @(posedge ref_clk_i);
        clr_go <= 1'b0;
    endtask : pin_low
    // Waits for the restart pulse; notes whether the core was held and the pin driven
    task automatic wait_ev(input logic want_res, output logic saw_rst);
        saw_rst = 1'b0;
        // A pulse source holds the core one cycle only, so look before the next edge
        #1;
        if (core_rst_o === 1'b1) saw_rst = 1'b1;
        for (int i = 0; i < 200; i++) begin
            @(posedge ref_clk_i);
            #1;
            if (core_rst_o === 1'b1) saw_rst = 1'b1;
            chk("pin_oe_n", 14'h0001, 14'(master_clear_n_oe_n));
            chk("pin_drv", 14'h0001, 14'(master_clear_n_drv));
            if ((want_res ? resume_o : pc_zero_o) === 1'b1) return;
        end
        chk("restart_pulse", 14'h0001, 14'h0000);
    endtask : wait_ev
    task automatic res(input logic [5:0] c, input logic t, input logic p);
        chk("cause", 14'(c), 14'(cause));
        chk("timeout", 14'(t), 14'(tof));
        chk("powerdown", 14'(p), 14'(pdf));
    endtask : res
    task automatic t_power_on;
        logic s;
        wait_ev(1'b0, s);
        res(6'h01, 1'b1, 1'b1);
        rd_chk("config", `RSOC_CFG_ADDR, 14'h3fff);
        chk("osc_mode", 14'h0003, 14'(osc_mode));
        wr(`RSOC_USER_ADDR, 14'h005a);
        wr(`RSOC_KEEP_ADDR, 14'h00a5);
        @(posedge ref_clk_i);
        pwr_go <= 1'b1;
        @(posedge ref_clk_i);
        pwr_go <= 1'b0;
        wait_ev(1'b0, s);
        res(6'h01, 1'b1, 1'b1);
        rd_chk("flags", `RSOC_FLAG_ADDR, 14'h0007);
        rd_chk("user", `RSOC_USER_ADDR, 14'h0000);
        rd_chk("keep", `RSOC_KEEP_ADDR, 14'h00a5);
    endtask : t_power_on
    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            wr(`RSOC_CFG_ADDR, 14'h0044 | 14'(m));
            repeat (2) @(posedge ref_clk_i);
            #1;
            chk("osc_mode", 14'(m), 14'(osc_mode));
            chk("both_pins", 14'(m != 3), 14'(both));
            chk("ext_clk", 14'(m == 2), 14'(ext));
            rd_chk("config", `RSOC_CFG_ADDR, 14'h3fe4 | 14'(m));
        end
    endtask : t_modes
    task automatic t_watchdog;
        logic s;
        wr(`RSOC_IMSK_ADDR, 14'h0008);
        wr(`RSOC_USER_ADDR, 14'h0033);
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("irq_masked", 14'h0000, 14'(irq_o));
        pulse_wd();
        wait_ev(1'b0, s);
        chk("core_held", 14'h0001, 14'(s));
        res(6'h08, 1'b0, 1'b1);
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("irq_set", 14'h0001, 14'(irq_o));
        rd_chk("user", `RSOC_USER_ADDR, 14'h0000);
        wr(`RSOC_FLAG_ADDR, 14'h0000);
        rd_chk("flags", `RSOC_FLAG_ADDR, 14'h0022);
        wr(`RSOC_IST_ADDR, 14'h003f);
        rd_chk("status", `RSOC_IST_ADDR, 14'h0000);
        chk("irq_clear", 14'h0000, 14'(irq_o));
        rd_chk("unmapped", 14'h1234, 14'h0000);
    endtask : t_watchdog
    task automatic t_wake;
        logic s;
        wr(`RSOC_USER_ADDR, 14'h0044);
        @(posedge ref_clk_i);
        sleep <= 1'b1;
        pulse_wd();
        wait_ev(1'b1, s);
        chk("core_held", 14'h0000, 14'(s));
        res(6'h10, 1'b0, 1'b0);
        rd_chk("user", `RSOC_USER_ADDR, 14'h0044);
        @(posedge ref_clk_i);
        iwake <= 1'b1;
        wait_ev(1'b1, s);
        @(posedge ref_clk_i);
        iwake <= 1'b0;
        sleep <= 1'b0;
        res(6'h10, 1'b1, 1'b0);
    endtask : t_wake
    task automatic t_clear;
        logic s;
        pin_low(8'(FILT));
        s = 1'b0;
        repeat (20) begin
            @(posedge ref_clk_i);
            #1;
            if (core_rst_o !== 1'b0) s = 1'b1;
        end
        chk("short_pulse", 14'h0000, 14'(s));
        pin_low(8'(FILT + 2));
        wait_ev(1'b0, s);
        chk("core_held", 14'h0001, 14'(s));
        res(6'h02, 1'b1, 1'b0);
        @(posedge ref_clk_i);
        sleep <= 1'b1;
        pin_low(8'h0c);
        wait_ev(1'b0, s);
        @(posedge ref_clk_i);
        sleep <= 1'b0;
        res(6'h04, 1'b1, 1'b0);
    endtask : t_clear
    task automatic t_brownout;
        logic s;
        @(posedge ref_clk_i);
        bo <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        chk("core_held", 14'h0001, 14'(core_rst_o));
        @(posedge ref_clk_i);
        bo <= 1'b0;
        wait_ev(1'b0, s);
        res(6'h20, 1'b1, 1'b1);
    endtask : t_brownout
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_power_on();
        t_modes();
        t_watchdog();
        t_wake();
        t_clear();
        t_brownout();
        close_out();
    end
endmodule : tb_rsoc_top
`default_nettype wire
